// ==== verilog/ssf_status_flags.sv ====
// Servo status output flag generator with APB configuration registers
`timescale 1ns/1ns

module ssf_status_flags
   import ssf_pkg::*;
#(
   parameter int CYC_PER_MS = SSF_CYC_PER_MS,
   parameter int SETTLE_SINGLE_MS = SSF_SETTLE_SINGLE_MS,
   parameter int SETTLE_MULTI_MS = SSF_SETTLE_MULTI_MS
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Pins from outside the clock domain
   input wire logic MULTI_AXIS_I,
   input wire logic FWD_START_I,
   input wire logic REV_START_I,
   // Internal drive state
   input wire logic SERVO_ON_I,
   input wire logic ALARM_I,
   input wire logic WARNING_I,
   input wire logic [SSF_CODE_W-1:0] WARNING_CODE_I,
   input wire logic STOP_WARNING_I,
   input wire logic [1:0] CTRL_MODE_I,
   input wire logic signed [SSF_SPD_W-1:0] MOTOR_SPEED_I,
   input wire logic signed [SSF_SPD_W-1:0] SET_SPEED_I,
   input wire logic [SSF_SPD_W-1:0] SPEED_LIMIT_I,
   input wire logic signed [SSF_DRP_W-1:0] DROOP_I,
   input wire logic signed [SSF_TRQ_W-1:0] TORQUE_I,
   input wire logic [SSF_TRQ_W-1:0] TORQUE_LIMIT_I,
   input wire logic GAIN_SET1_I,
   input wire logic GAIN_SET2_I,
   input wire logic ABS_UNDETERMINED_I,
   input wire logic RIDE_THROUGH_ACTIVE_I,
   input wire logic FULL_LOOP_I,
   // Status outputs
   output logic FAULT_N_O,
   output logic READY_OUT_O,
   output logic IN_POSITION_O,
   output logic SPEED_REACHED_O,
   output logic WARNING_FLAG_O,
   output logic BATTERY_WARN_FLAG_O,
   output logic STOP_WARNING_FLAG_O,
   output logic GAIN_SWITCH_ACTIVE_O,
   output logic GAIN_SWITCH2_ACTIVE_O,
   output logic ABS_POS_LOST_O,
   output logic POWER_DIP_RIDE_THROUGH_O,
   output logic FULL_LOOP_ACTIVE_O,
   output logic BRAKE_INTERLOCK_O,
   output logic SPEED_LIMITING_O,
   output logic ZERO_SPEED_FLAG_O,
   output logic TORQUE_LIMITING_O
);

   // ***********************************************
   // Parameter checks
   // ***********************************************
   localparam int MS_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;

   generate
      if (CYC_PER_MS < 1 || SETTLE_SINGLE_MS < 1 || SETTLE_MULTI_MS < 1 ||
          SETTLE_SINGLE_MS > 65535 || SETTLE_MULTI_MS > 65535) begin : g_bad_param
         $error("ssf_status_flags: timing parameters out of range");
      end
   endgenerate

   localparam logic [MS_W-1:0] MS_LAST = MS_W'(CYC_PER_MS - 1);
   localparam logic [15:0] SETTLE_SINGLE = 16'(SETTLE_SINGLE_MS);
   localparam logic [15:0] SETTLE_MULTI = 16'(SETTLE_MULTI_MS);

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
      end else begin
         pin_meta <= {MULTI_AXIS_I, REV_START_I, FWD_START_I};
         pin_sync <= pin_meta;
      end
   end

   logic fwd_start;
   logic rev_start;
   logic multi_axis;
   assign fwd_start = pin_sync[0];
   assign rev_start = pin_sync[1];
   assign multi_axis = pin_sync[2];

   // ***********************************************
   // Millisecond tick and power-on settling
   // ***********************************************
   logic [MS_W-1:0] ms_div;
   logic ms_tick;
   logic [15:0] settle_ms;
   logic settled;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ms_div <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (ms_div == MS_LAST);
         ms_div <= (ms_div == MS_LAST) ? '0 : ms_div + MS_W'(1);
      end
   end

   // Window picked from the strap; the strap is meant static after power-on
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         settle_ms <= 16'h0000;
         settled <= 1'b0;
      end else if (!settled && ms_tick) begin
         settle_ms <= settle_ms + 16'h0001;
         if (settle_ms + 16'h0001 >= (multi_axis ? SETTLE_MULTI : SETTLE_SINGLE)) begin
            settled <= 1'b1;
         end
      end
   end

   // ***********************************************
   // APB registers
   // ***********************************************
   logic [2:0] ctrl;
   logic [SSF_DRP_W-1:0] inpos_range;
   logic [15:0] brake_delay;
   logic [SSF_SPD_W-1:0] zspd_level;
   logic [31:0] stat_word;
   logic wr_en;
   logic setup;
   logic addr_ok;

   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
   assign setup = PSEL_I && !PENABLE_I;
   assign addr_ok = (PADDR_I == SSF_CTRL_OFS) || (PADDR_I == SSF_INPOS_OFS) ||
                    (PADDR_I == SSF_BRAKE_OFS) || (PADDR_I == SSF_ZSPD_OFS) ||
                    (PADDR_I == SSF_STAT_OFS);

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl <= SSF_CTRL_RST;
         inpos_range <= SSF_INPOS_RST;
         brake_delay <= SSF_BRAKE_RST;
         zspd_level <= SSF_ZSPD_RST;
      end else if (wr_en) begin
         unique case (PADDR_I)
            SSF_CTRL_OFS: ctrl <= PWDATA_I[2:0];
            SSF_INPOS_OFS: inpos_range <= PWDATA_I[SSF_DRP_W-1:0];
            SSF_BRAKE_OFS: brake_delay <= PWDATA_I[15:0];
            SSF_ZSPD_OFS: zspd_level <= PWDATA_I[SSF_SPD_W-1:0];
            default: ;
         endcase
      end
   end

   // Read data is latched in the setup phase so the answer comes from a flop
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PRDATA_O <= 32'h0000_0000;
         PSLVERR_O <= 1'b0;
         PREADY_O <= 1'b0;
      end else begin
         PREADY_O <= 1'b1;
         if (setup) begin
            PSLVERR_O <= !addr_ok;
            unique case (PADDR_I)
               SSF_CTRL_OFS: PRDATA_O <= {29'h0, ctrl};
               SSF_INPOS_OFS: PRDATA_O <= {8'h00, inpos_range};
               SSF_BRAKE_OFS: PRDATA_O <= {16'h0000, brake_delay};
               SSF_ZSPD_OFS: PRDATA_O <= {16'h0000, zspd_level};
               SSF_STAT_OFS: PRDATA_O <= stat_word;
               default: PRDATA_O <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ***********************************************
   // Magnitudes and comparisons
   // ***********************************************
   logic [SSF_SPD_W:0] spd_mag;
   logic [SSF_SPD_W:0] set_mag;
   logic [SSF_SPD_W:0] err_mag;
   logic [SSF_SPD_W+1:0] sa_tol;
   logic [SSF_DRP_W:0] drp_mag;
   logic [SSF_TRQ_W:0] trq_mag;
   logic signed [SSF_SPD_W:0] spd_err;

   assign spd_mag = MOTOR_SPEED_I[SSF_SPD_W-1] ? (SSF_SPD_W+1)'(-MOTOR_SPEED_I) : (SSF_SPD_W+1)'(MOTOR_SPEED_I);
   assign set_mag = SET_SPEED_I[SSF_SPD_W-1] ? (SSF_SPD_W+1)'(-SET_SPEED_I) : (SSF_SPD_W+1)'(SET_SPEED_I);
   assign spd_err = (SSF_SPD_W+1)'(MOTOR_SPEED_I) - (SSF_SPD_W+1)'(SET_SPEED_I);
   assign err_mag = spd_err[SSF_SPD_W] ? (SSF_SPD_W+1)'(-spd_err) : (SSF_SPD_W+1)'(spd_err);
   // Five percent taken as a divide by twenty, truncating
   assign sa_tol = (SSF_SPD_W+2)'(set_mag / (SSF_SPD_W+1)'(SSF_SA_DIVISOR)) + (SSF_SPD_W+2)'(SSF_SA_OFFSET);
   assign drp_mag = DROOP_I[SSF_DRP_W-1] ? (SSF_DRP_W+1)'(-DROOP_I) : (SSF_DRP_W+1)'(DROOP_I);
   assign trq_mag = TORQUE_I[SSF_TRQ_W-1] ? (SSF_TRQ_W+1)'(-TORQUE_I) : (SSF_TRQ_W+1)'(TORQUE_I);

   logic mode_pos;
   logic mode_spd;
   logic mode_trq;
   assign mode_pos = (CTRL_MODE_I == SSF_MODE_POS);
   assign mode_spd = (CTRL_MODE_I == SSF_MODE_SPD);
   assign mode_trq = (CTRL_MODE_I == SSF_MODE_TRQ);

   // ***********************************************
   // Next values of the flags
   // ***********************************************
   logic next_speed_reached;
   logic next_battery;
   logic bat_code;

   assign bat_code = WARNING_I && ((WARNING_CODE_I == SSF_CODE_BATT_CABLE) || (WARNING_CODE_I == SSF_CODE_BATT));

   always_comb begin
      next_speed_reached = 1'b0;
      if (SERVO_ON_I && mode_spd) begin
         if (set_mag <= (SSF_SPD_W+1)'(SSF_SA_FLOOR)) begin
            next_speed_reached = 1'b1;
         end else begin
            next_speed_reached = ((SSF_SPD_W+2)'(err_mag) <= sa_tol);
         end
         if (ctrl[SSF_CTRL_ANALOG_BIT] && !fwd_start && !rev_start) begin
            next_speed_reached = 1'b0;
         end
      end
   end

   assign next_battery = (bat_code || !settled) && !ctrl[SSF_CTRL_BATTLESS_BIT];

   // ***********************************************
   // Status flag flops
   // ***********************************************
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FAULT_N_O <= 1'b0;
         READY_OUT_O <= 1'b0;
         IN_POSITION_O <= 1'b0;
         SPEED_REACHED_O <= 1'b0;
         WARNING_FLAG_O <= 1'b1;
         BATTERY_WARN_FLAG_O <= 1'b0;
         STOP_WARNING_FLAG_O <= 1'b1;
      end else begin
         FAULT_N_O <= settled && !ALARM_I;
         READY_OUT_O <= SERVO_ON_I && !ALARM_I;
         IN_POSITION_O <= mode_pos && (drp_mag <= (SSF_DRP_W+1)'(inpos_range));
         SPEED_REACHED_O <= next_speed_reached;
         WARNING_FLAG_O <= WARNING_I || !settled;
         BATTERY_WARN_FLAG_O <= next_battery;
         STOP_WARNING_FLAG_O <= STOP_WARNING_I || !settled;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         GAIN_SWITCH_ACTIVE_O <= 1'b0;
         GAIN_SWITCH2_ACTIVE_O <= 1'b0;
         ABS_POS_LOST_O <= 1'b0;
         POWER_DIP_RIDE_THROUGH_O <= 1'b0;
         FULL_LOOP_ACTIVE_O <= 1'b0;
      end else begin
         GAIN_SWITCH_ACTIVE_O <= GAIN_SET1_I;
         GAIN_SWITCH2_ACTIVE_O <= GAIN_SET2_I;
         ABS_POS_LOST_O <= ABS_UNDETERMINED_I;
         POWER_DIP_RIDE_THROUGH_O <= ctrl[SSF_CTRL_RIDE_BIT] && RIDE_THROUGH_ACTIVE_I;
         FULL_LOOP_ACTIVE_O <= FULL_LOOP_I;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SPEED_LIMITING_O <= 1'b0;
         TORQUE_LIMITING_O <= 1'b0;
      end else begin
         SPEED_LIMITING_O <= SERVO_ON_I && mode_trq && (spd_mag >= (SSF_SPD_W+1)'(SPEED_LIMIT_I));
         TORQUE_LIMITING_O <= SERVO_ON_I && !mode_trq && (trq_mag >= (SSF_TRQ_W+1)'(TORQUE_LIMIT_I));
      end
   end

   // ***********************************************
   // Zero speed hysteresis
   // ***********************************************
   // Off-level computed one bit wider so a large level cannot wrap
   logic [SSF_SPD_W+1:0] zsp_off;
   assign zsp_off = (SSF_SPD_W+2)'(zspd_level) + (SSF_SPD_W+2)'(SSF_ZSP_HYST);

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ZERO_SPEED_FLAG_O <= 1'b0;
      end else if (spd_mag <= (SSF_SPD_W+1)'(zspd_level)) begin
         ZERO_SPEED_FLAG_O <= 1'b1;
      end else if ((SSF_SPD_W+2)'(spd_mag) >= zsp_off) begin
         ZERO_SPEED_FLAG_O <= 1'b0;
      end
   end

   // ***********************************************
   // Brake interlock
   // ***********************************************
   // Release is held back by the brake delay after servo-on;
   // dropping is immediate so the brake never lags a fault
   logic [15:0] brake_ms;
   logic brake_ok;
   assign brake_ok = SERVO_ON_I && !ALARM_I;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         brake_ms <= 16'h0000;
         BRAKE_INTERLOCK_O <= 1'b0;
      end else if (!brake_ok) begin
         brake_ms <= 16'h0000;
         BRAKE_INTERLOCK_O <= 1'b0;
      end else if (brake_ms >= brake_delay) begin
         BRAKE_INTERLOCK_O <= 1'b1;
      end else if (ms_tick) begin
         brake_ms <= brake_ms + 16'h0001;
      end
   end

   // ***********************************************
   // Status word
   // ***********************************************
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[SSF_ST_FAULT_N] = FAULT_N_O;
      stat_word[SSF_ST_READY] = READY_OUT_O;
      stat_word[SSF_ST_INPOS] = IN_POSITION_O;
      stat_word[SSF_ST_SA] = SPEED_REACHED_O;
      stat_word[SSF_ST_WNG] = WARNING_FLAG_O;
      stat_word[SSF_ST_BATTERY_WARN_FLAG] = BATTERY_WARN_FLAG_O;
      stat_word[SSF_ST_STOPW] = STOP_WARNING_FLAG_O;
      stat_word[SSF_ST_GAIN1] = GAIN_SWITCH_ACTIVE_O;
      stat_word[SSF_ST_GAIN2] = GAIN_SWITCH2_ACTIVE_O;
      stat_word[SSF_ST_ABSL] = ABS_POS_LOST_O;
      stat_word[SSF_ST_RIDE] = POWER_DIP_RIDE_THROUGH_O;
      stat_word[SSF_ST_FULL] = FULL_LOOP_ACTIVE_O;
      stat_word[SSF_ST_BRAKE] = BRAKE_INTERLOCK_O;
      stat_word[SSF_ST_VLIM] = SPEED_LIMITING_O;
      stat_word[SSF_ST_ZSP] = ZERO_SPEED_FLAG_O;
      stat_word[SSF_ST_TLIM] = TORQUE_LIMITING_O;
      stat_word[SSF_ST_SETTLED] = settled;
   end

endmodule : ssf_status_flags

// ==== verilog/ssf_pkg.sv ====
// Shared constants for the servo status flag block
package ssf_pkg;

   // ***********************************************
   // Data widths
   // ***********************************************
   localparam int SSF_SPD_W = 16;
   localparam int SSF_TRQ_W = 16;
   localparam int SSF_DRP_W = 24;
   localparam int SSF_CODE_W = 12;

   // ***********************************************
   // Register byte offsets
   // ***********************************************
   localparam logic [7:0] SSF_CTRL_OFS = 8'h00;
   localparam logic [7:0] SSF_INPOS_OFS = 8'h04;
   localparam logic [7:0] SSF_BRAKE_OFS = 8'h08;
   localparam logic [7:0] SSF_ZSPD_OFS = 8'h0c;
   localparam logic [7:0] SSF_STAT_OFS = 8'h10;

   // ***********************************************
   // Control register fields and reset values
   // ***********************************************
   localparam int SSF_CTRL_RIDE_BIT = 0;
   localparam int SSF_CTRL_BATTLESS_BIT = 1;
   localparam int SSF_CTRL_ANALOG_BIT = 2;
   localparam logic [2:0] SSF_CTRL_RST = 3'h0;
   localparam logic [SSF_DRP_W-1:0] SSF_INPOS_RST = 24'h000064;
   localparam logic [15:0] SSF_BRAKE_RST = 16'h0000;
   localparam logic [SSF_SPD_W-1:0] SSF_ZSPD_RST = 16'h0032;

   // ***********************************************
   // Control modes
   // ***********************************************
   localparam logic [1:0] SSF_MODE_POS = 2'h0;
   localparam logic [1:0] SSF_MODE_SPD = 2'h1;
   localparam logic [1:0] SSF_MODE_TRQ = 2'h2;

   // ***********************************************
   // Warning codes for the battery flag
   // ***********************************************
   localparam logic [SSF_CODE_W-1:0] SSF_CODE_BATT_CABLE = 12'h092;
   localparam logic [SSF_CODE_W-1:0] SSF_CODE_BATT = 12'h09f;

   // ***********************************************
   // Speed figures in r/min (mm/s for linear motors)
   // ***********************************************
   localparam logic [SSF_SPD_W-1:0] SSF_SA_FLOOR = 16'h0014;
   localparam logic [SSF_SPD_W-1:0] SSF_SA_OFFSET = 16'h0014;
   localparam logic [SSF_SPD_W-1:0] SSF_SA_DIVISOR = 16'h0014;
   localparam logic [SSF_SPD_W-1:0] SSF_ZSP_HYST = 16'h0014;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int SSF_CLK_HZ = 10_000_000;
   localparam int SSF_MS_PER_S = 1000;
   localparam int SSF_CYC_PER_MS = SSF_CLK_HZ / SSF_MS_PER_S;
   localparam int SSF_SETTLE_SINGLE_MS = 3000;
   localparam int SSF_SETTLE_MULTI_MS = 3750;

   // ***********************************************
   // Status register bit positions
   // ***********************************************
   typedef enum int {
      SSF_ST_FAULT_N = 0,
      SSF_ST_READY = 1,
      SSF_ST_INPOS = 2,
      SSF_ST_SA = 3,
      SSF_ST_WNG = 4,
      SSF_ST_BATTERY_WARN_FLAG = 5,
      SSF_ST_STOPW = 6,
      SSF_ST_GAIN1 = 7,
      SSF_ST_GAIN2 = 8,
      SSF_ST_ABSL = 9,
      SSF_ST_RIDE = 10,
      SSF_ST_FULL = 11,
      SSF_ST_BRAKE = 12,
      SSF_ST_VLIM = 13,
      SSF_ST_ZSP = 14,
      SSF_ST_TLIM = 15,
      SSF_ST_SETTLED = 16,
      SSF_ST_COUNT = 17
   } ssf_stat_type;

endpackage : ssf_pkg

// ==== testbench/ssf_status_flags_properties.sv ====
// Concurrent checks on the status flag outputs
`timescale 1ns/1ns
module ssf_status_flags_chk
   import ssf_pkg::*;
#(
   parameter int CYC_PER_MS = 4,
   parameter int SETTLE_SINGLE_MS = 5,
   parameter int SETTLE_MULTI_MS = 8
) (
   // Clock, reset and causes
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic SERVO_ON_I,
   input wire logic ALARM_I,
   input wire logic WARNING_I,
   input wire logic STOP_WARNING_I,
   input wire logic [1:0] CTRL_MODE_I,
   input wire logic GAIN_SET1_I,
   input wire logic GAIN_SET2_I,
   input wire logic ABS_UNDETERMINED_I,
   // Flags
   input wire logic FAULT_N_O,
   input wire logic READY_OUT_O,
   input wire logic IN_POSITION_O,
   input wire logic SPEED_REACHED_O,
   input wire logic WARNING_FLAG_O,
   input wire logic STOP_WARNING_FLAG_O,
   input wire logic GAIN_SWITCH_ACTIVE_O,
   input wire logic GAIN_SWITCH2_ACTIVE_O,
   input wire logic ABS_POS_LOST_O,
   input wire logic BRAKE_INTERLOCK_O,
   input wire logic SPEED_LIMITING_O,
   input wire logic TORQUE_LIMITING_O
);
   // ***************
   // Settling counter
   // ***************
   // Shortest window only; the multi-axis strap can only lengthen it
   localparam int LIM = SETTLE_SINGLE_MS * CYC_PER_MS;
   int cnt;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cnt <= 0;
      end else if (cnt < LIM) begin
         cnt <= cnt + 1;
      end
   end
   // ***************
   // Properties
   // ***************
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   AST_FAULT_ALARM: assert property (ALARM_I |=> !FAULT_N_O) else $error("fault output high on alarm");
   AST_SETTLE_EARLY: assert property (cnt < LIM - 2 |-> !FAULT_N_O && WARNING_FLAG_O && STOP_WARNING_FLAG_O)
      else $error("flags settled too early");
   AST_INPOS_MODE: assert property (CTRL_MODE_I != SSF_MODE_POS |=> !IN_POSITION_O) else $error("in-position");
   AST_READY_ON: assert property (SERVO_ON_I && !ALARM_I |=> READY_OUT_O) else $error("ready missing");
   AST_SA_BLOCK: assert property (!SERVO_ON_I || CTRL_MODE_I != SSF_MODE_SPD |=> !SPEED_REACHED_O)
      else $error("speed reached outside speed mode");
   AST_WARN: assert property (WARNING_I |=> WARNING_FLAG_O) else $error("warning flag missing");
   AST_STOPW: assert property (STOP_WARNING_I |=> STOP_WARNING_FLAG_O) else $error("stop warning missing");
   AST_GAIN: assert property (1'b1 |=> GAIN_SWITCH_ACTIVE_O == $past(GAIN_SET1_I) &&
      GAIN_SWITCH2_ACTIVE_O == $past(GAIN_SET2_I)) else $error("gain outputs wrong");
   AST_ABS: assert property (1'b1 |=> ABS_POS_LOST_O == $past(ABS_UNDETERMINED_I)) else $error("abs lost");
   AST_BRAKE: assert property ((!SERVO_ON_I || ALARM_I)[*2] |-> !BRAKE_INTERLOCK_O) else $error("brake on");
   AST_VLIM: assert property (!SERVO_ON_I || CTRL_MODE_I != SSF_MODE_TRQ |=> !SPEED_LIMITING_O)
      else $error("speed limiting outside torque mode");
   AST_TLIM: assert property (!SERVO_ON_I || CTRL_MODE_I == SSF_MODE_TRQ |=> !TORQUE_LIMITING_O)
      else $error("torque limiting wrongly set");
   cover property ($rose(FAULT_N_O));
   cover property ($rose(BRAKE_INTERLOCK_O));
   cover property ($rose(SPEED_REACHED_O));
endmodule : ssf_status_flags_chk

bind ssf_status_flags ssf_status_flags_chk #(.CYC_PER_MS(CYC_PER_MS), .SETTLE_SINGLE_MS(SETTLE_SINGLE_MS),
   .SETTLE_MULTI_MS(SETTLE_MULTI_MS)) chk_u (.CLK_I, .RST_N_I, .SERVO_ON_I, .ALARM_I, .WARNING_I, .STOP_WARNING_I,
   .CTRL_MODE_I, .GAIN_SET1_I, .GAIN_SET2_I, .ABS_UNDETERMINED_I, .FAULT_N_O, .READY_OUT_O, .IN_POSITION_O,
   .SPEED_REACHED_O, .WARNING_FLAG_O, .STOP_WARNING_FLAG_O, .GAIN_SWITCH_ACTIVE_O, .GAIN_SWITCH2_ACTIVE_O,
   .ABS_POS_LOST_O, .BRAKE_INTERLOCK_O, .SPEED_LIMITING_O, .TORQUE_LIMITING_O);

// ==== testbench/ssf_plc_model.sv ====
// Host controller model that scans the discrete status outputs
`timescale 1ns/1ns
module ssf_plc_model (
   // Scan clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Discrete inputs and scanned image
   input wire logic [15:0] flags_i,
   output logic [15:0] image_o
);
   // Scan every edge; a slower scan would hide one-cycle glitches
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         image_o <= 16'h0;
      end else begin
         image_o <= flags_i;
      end
   end
endmodule : ssf_plc_model

// ==== testbench/ssf_status_flags_tb.sv ====
// Self-checking bench for the servo status flag block
`timescale 1ns/1ns
module ssf_status_flags_tb
   import ssf_pkg::*;
();
   // ***************
   // Signals and tables
   // ***************
   typedef struct packed {
      logic srv;
      logic [1:0] mode;
      logic [15:0] spd, setv, trq;
      logic [23:0] drp;
      logic [5:0] exp;
   } ssf_row_type;
   // Expected: ready, in-position, speed reached, speed limit, zero speed, torque limit
   ssf_row_type rows [19] = '{'{1'h1, 2'h0, 16'h0, 16'h0, 16'h0, 24'h64, 6'h32},
      '{1'h1, 2'h0, 16'h0, 16'h0, 16'h0, 24'h65, 6'h22}, '{1'h1, 2'h0, 16'h0, 16'h0, 16'h0, 24'hffff9c, 6'h32},
      '{1'h1, 2'h1, 16'h42e, 16'h3e8, 16'h0, 24'h0, 6'h28}, '{1'h1, 2'h1, 16'h42f, 16'h3e8, 16'h0, 24'h0, 6'h20},
      '{1'h1, 2'h1, 16'h3a2, 16'h3e8, 16'h0, 24'h0, 6'h28}, '{1'h1, 2'h1, 16'h1f4, 16'h14, 16'h0, 24'h0, 6'h28},
      '{1'h1, 2'h1, 16'h1f4, 16'h15, 16'h0, 24'h0, 6'h20}, '{1'h0, 2'h1, 16'h1f4, 16'h14, 16'h0, 24'h0, 6'h00},
      '{1'h1, 2'h2, 16'h3e8, 16'h3e8, 16'h258, 24'h0, 6'h24}, '{1'h1, 2'h2, 16'h3e7, 16'h3e8, 16'h258, 24'h0, 6'h20},
      '{1'h1, 2'h2, 16'hfc18, 16'h3e8, 16'h258, 24'h0, 6'h24}, '{1'h0, 2'h2, 16'hfc18, 16'h3e8, 16'h258, 24'h0, 6'h0},
      '{1'h1, 2'h0, 16'h32, 16'h0, 16'h1f4, 24'h0, 6'h33}, '{1'h1, 2'h0, 16'h45, 16'h0, 16'hfe0d, 24'h0, 6'h32},
      '{1'h1, 2'h0, 16'hffba, 16'h0, 16'hfe0d, 24'h0, 6'h30}, '{1'h1, 2'h0, 16'h33, 16'h0, 16'h0, 24'h0, 6'h30},
      '{1'h1, 2'h0, 16'hffce, 16'h0, 16'hfe0c, 24'h0, 6'h33}, '{1'h1, 2'h1, 16'h0, 16'h0, 16'h258, 24'h0, 6'h2b}};
   logic [7:0] ra [6] = '{SSF_CTRL_OFS, SSF_INPOS_OFS, SSF_BRAKE_OFS, SSF_ZSPD_OFS, SSF_STAT_OFS, 8'h14};
   logic [32:0] rv [6] = '{33'h0, 33'h64, 33'h0, 33'h32, 33'h14005, 33'h100000000};
   logic [11:0] codes [3] = '{SSF_CODE_BATT_CABLE, SSF_CODE_BATT, 12'h091};
   logic [15:0] zs [3] = '{16'h64, 16'hff89, 16'h78};
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err, pready, pslverr;
   logic multi = 1'h0, fwd = 1'h0, rev = 1'h0, srv = 1'h0, fault_n = 1'h0, warning_flag = 1'h0, stopw = 1'h0;
   logic g1 = 1'h0, g2 = 1'h0, absu = 1'h0, ride = 1'h0, full = 1'h0;
   logic [1:0] mode = 2'h0;
   logic [7:0] paddr = 8'h0;
   logic [11:0] code = 12'h0;
   logic [15:0] spd = 16'h0, setv = 16'h0, trq = 16'h0, plc, slim = 16'h3e8, tlim = 16'h1f4;
   logic [23:0] drp = 24'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   wire logic [15:0] flags;
   int num_errors = 0, tests_run = 0, cyc_cnt = 0;

   ssf_status_flags #(.CYC_PER_MS(4), .SETTLE_SINGLE_MS(5), .SETTLE_MULTI_MS(8)) dut_u (
      .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .MULTI_AXIS_I(multi),
      .FWD_START_I(fwd), .REV_START_I(rev), .SERVO_ON_I(srv), .ALARM_I(fault_n), .WARNING_I(warning_flag), .WARNING_CODE_I(code),
      .STOP_WARNING_I(stopw), .CTRL_MODE_I(mode), .MOTOR_SPEED_I(spd), .SET_SPEED_I(setv), .SPEED_LIMIT_I(slim),
      .DROOP_I(drp), .TORQUE_I(trq), .TORQUE_LIMIT_I(tlim), .GAIN_SET1_I(g1), .GAIN_SET2_I(g2),
      .ABS_UNDETERMINED_I(absu), .RIDE_THROUGH_ACTIVE_I(ride), .FULL_LOOP_I(full), .FAULT_N_O(flags[0]),
      .READY_OUT_O(flags[1]), .IN_POSITION_O(flags[2]), .SPEED_REACHED_O(flags[3]), .WARNING_FLAG_O(flags[4]),
      .BATTERY_WARN_FLAG_O(flags[5]), .STOP_WARNING_FLAG_O(flags[6]), .GAIN_SWITCH_ACTIVE_O(flags[7]),
      .GAIN_SWITCH2_ACTIVE_O(flags[8]), .ABS_POS_LOST_O(flags[9]), .POWER_DIP_RIDE_THROUGH_O(flags[10]),
      .FULL_LOOP_ACTIVE_O(flags[11]), .BRAKE_INTERLOCK_O(flags[12]), .SPEED_LIMITING_O(flags[13]),
      .ZERO_SPEED_FLAG_O(flags[14]), .TORQUE_LIMITING_O(flags[15]));
   ssf_plc_model plc_u (.clk_i(clk), .rst_n_i(rst_n), .flags_i(flags), .image_o(plc));

   // ***************
   // Tasks
   // ***************
   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 3000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic settle(input int early, input int late);
      rst_n <= 1'h0;
      cyc(5);
      rst_n <= 1'h1;
      cyc(early);
      chk({plc[SSF_ST_FAULT_N], plc[SSF_ST_WNG], plc[SSF_ST_BATTERY_WARN_FLAG], plc[SSF_ST_STOPW]}, 40'h7);
      cyc(late - early);
      chk({plc[SSF_ST_FAULT_N], plc[SSF_ST_WNG], plc[SSF_ST_BATTERY_WARN_FLAG], plc[SSF_ST_STOPW]}, 40'h8);
      $display("test settle done");
   endtask : settle
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // ***************
   // Main sequence
   // ***************
   initial begin
      settle(12, 30);
      for (int i = 0; i < 6; i++) begin
         apb(1'h0, ra[i], 32'h0);
         chk({err, rd}, rv[i]);
      end
      for (int i = 0; i < 19; i++) begin
         {srv, mode, spd, setv, trq, drp} <= rows[i][80:6];
         cyc(3);
         chk({plc[1], plc[2], plc[3], plc[13], plc[14], plc[15]}, rows[i].exp);
      end
      // Raised level: -119 now holds
      apb(1'h1, SSF_ZSPD_OFS, 32'h64);
      for (int i = 0; i < 3; i++) begin
         spd <= zs[i];
         cyc(3);
         chk(plc[SSF_ST_ZSP], i < 2);
      end
      $display("test table done");
      {warning_flag, stopw} <= 2'h3;
      for (int i = 0; i < 3; i++) begin
         code <= codes[i];
         cyc(3);
         chk({plc[SSF_ST_WNG], plc[SSF_ST_BATTERY_WARN_FLAG], plc[SSF_ST_STOPW]}, {1'h1, i < 2, 1'h1});
      end
      apb(1'h1, SSF_CTRL_OFS, 32'h2);
      code <= SSF_CODE_BATT;
      cyc(3);
      chk(plc[SSF_ST_BATTERY_WARN_FLAG], 40'h0);
      {warning_flag, stopw} <= 2'h0;
      cyc(3);
      chk({plc[SSF_ST_WNG], plc[SSF_ST_BATTERY_WARN_FLAG], plc[SSF_ST_STOPW]}, 40'h0);
      $display("test warnings done");
      {srv, mode, spd} <= {1'h1, SSF_MODE_SPD, 16'h0};
      cyc(6);
      chk({plc[SSF_ST_FAULT_N], plc[SSF_ST_READY], plc[SSF_ST_BRAKE]}, 40'h7);
      fault_n <= 1'h1;
      cyc(3);
      chk({plc[SSF_ST_FAULT_N], plc[SSF_ST_READY], plc[SSF_ST_BRAKE]}, 40'h0);
      {fault_n, srv} <= 2'h0;
      apb(1'h1, SSF_BRAKE_OFS, 32'h3);
      srv <= 1'h1;
      cyc(6);
      chk(plc[SSF_ST_BRAKE], 40'h0);
      cyc(14);
      chk(plc[SSF_ST_BRAKE], 40'h1);
      srv <= 1'h0;
      $display("test alarm and brake done");
      for (int i = 0; i < 4; i++) begin
         {g1, g2, absu, full} <= 4'h8 >> i;
         cyc(3);
         chk({plc[SSF_ST_GAIN1], plc[SSF_ST_GAIN2], plc[SSF_ST_ABSL], plc[SSF_ST_FULL]}, 40'h8 >> i);
      end
      {full, ride} <= 2'h1;
      apb(1'h1, SSF_CTRL_OFS, 32'h0);
      cyc(3);
      chk(plc[SSF_ST_RIDE], 40'h0);
      apb(1'h1, SSF_CTRL_OFS, 32'h5);
      cyc(3);
      chk(plc[SSF_ST_RIDE], 40'h1);
      $display("test state outputs done");
      // Start pins pass a synchroniser, so allow extra edges
      {srv, ride, spd, setv} <= {2'h2, 16'h3e8, 16'h3e8};
      cyc(6);
      chk(plc[SSF_ST_SA], 40'h0);
      fwd <= 1'h1;
      cyc(6);
      chk(plc[SSF_ST_SA], 40'h1);
      {fwd, rev} <= 2'h1;
      cyc(6);
      chk(plc[SSF_ST_SA], 40'h1);
      {rev, srv, spd, setv} <= 34'h0;
      $display("test analog start done");
      multi <= 1'h1;
      settle(28, 40);
      print_verdict();
   end
endmodule : ssf_status_flags_tb
